// ---- rtl/dpi_pin_if.v ----
// Purpose: device-side logic behind the x8 data and control pins
// Assumes: ck, strobes and data sampled by clk_sys, far slower than it
// Notes: command, write-capture and read-drive path, termination control
//
// Operation
// - high mask sample discards that write byte
// - mask ball reused as termination strobe
// - registered odt switches termination on/off
// - termination only on data, strobe, mask
// - odt ignored when disabled by mode load
// - commands decoded from cs, ras, cas, we
// - active-low reset acts without the clock
// - one shared eight-bit bidirectional data bus
// - read strobe edges aligned with read data
// - termination strobe disables mask, adds termination
// - chip select high masks every command
// - command inputs sampled at rising ck edge, write data and mask on each strobe edge
`include "dpi_regs.vh"
module dpi_pin_if #(
	parameter AW = 14,
	parameter BW = 3
) (
	input wire clk_sys,
	input wire reset,
	input wire mem_reset_n,
	input wire ck,
	input wire cs_n,
	input wire ras_n,
	input wire cas_n,
	input wire we_n,
	input wire odt,
	input wire [BW-1:0] ba,
	input wire [AW-1:0] addr,
	input wire dm_in,
	input wire [7:0] dq_in,
	output reg [7:0] dq_out,
	output reg dq_oe,
	input wire dqs_in,
	output reg dqs_out,
	output reg dqs_n_out,
	output reg dqs_oe,
	output reg term_dq,
	output reg term_tdqs,
	output reg tdqs_en,
	output reg odt_en,
	output reg cmd_valid,
	output reg [2:0] cmd_code,
	output reg [7:0] wr_data,
	output reg wr_valid,
	output reg wr_last,
	input wire [7:0] rd_data,
	output reg rd_take
);
	localparam SW = 16 + AW + BW;

	// ********************************
	// pin sampling
	// ********************************
	wire [SW-1:0] pin_f;
	dpi_sync3 #(
		.W(SW)
	) u_sync (
		.clk_sys(clk_sys),
		.reset(reset),
		.d({dq_in, addr, ba, dqs_in, dm_in, odt, we_n, cas_n, ras_n, cs_n, ck}),
		.q(pin_f)
	);

	wire ck_f = pin_f[0];
	wire cs_f = pin_f[1];
	wire ras_f = pin_f[2];
	wire cas_f = pin_f[3];
	wire we_f = pin_f[4];
	wire odt_f = pin_f[5];
	wire dm_f = pin_f[6];
	wire dqs_f = pin_f[7];
	wire [BW-1:0] ba_f = pin_f[8+BW-1:8];
	wire [AW-1:0] addr_f = pin_f[8+BW+AW-1:8+BW];
	wire [7:0] dq_f = pin_f[SW-1:SW-8];

	function [2:0] dpi_decode;
		input cs_b;
		input ras_b;
		input cas_b;
		input we_b;
		begin
			if (cs_b) begin
				dpi_decode = `DPI_CMD_NOP;
			end else begin
				dpi_decode = {ras_b, cas_b, we_b};
			end
		end
	endfunction

	reg ck_prev_r;
	reg dqs_prev_r;
	wire ck_rise = ck_f & ~ck_prev_r;
	wire ck_edge = ck_f ^ ck_prev_r;
	wire dqs_edge = dqs_f ^ dqs_prev_r;
	wire [2:0] cmd_now = dpi_decode(cs_f, ras_f, cas_f, we_f);

	reg [3:0] wr_beats_r;
	reg [3:0] rd_beats_r;
	wire [3:0] wr_beats_nxt = wr_beats_r - 4'h1;
	wire [3:0] rd_beats_nxt = rd_beats_r - 4'h1;

	// termination follows the state the same ck rise leaves behind
	wire mr_load = ck_rise && cmd_now == `DPI_CMD_MRS && ba_f == `DPI_MR_ODT_TDQS;
	wire bus_idle = wr_beats_r == 4'h0 && rd_beats_r == 4'h0;
	wire rd_start = ck_rise && cmd_now == `DPI_CMD_RD && bus_idle;
	wire odt_en_nxt = mr_load ? (addr_f[`DPI_RTT_BIT0] | addr_f[`DPI_RTT_BIT1] | addr_f[`DPI_RTT_BIT2]) : odt_en;
	wire tdqs_en_nxt = mr_load ? addr_f[`DPI_TDQS_BIT] : tdqs_en;
	wire drive_nxt = dq_oe | rd_start;

	// ********************************
	// control and data path
	// ********************************
	// pin reset clears state at once, with no clock edge needed
	always @(posedge clk_sys or negedge mem_reset_n) begin
		if (!mem_reset_n) begin
			ck_prev_r <= 1'b0;
			dqs_prev_r <= 1'b0;
			wr_beats_r <= 4'h0;
			rd_beats_r <= 4'h0;
			dq_out <= 8'h00;
			dq_oe <= 1'b0;
			dqs_out <= 1'b0;
			dqs_n_out <= 1'b1;
			dqs_oe <= 1'b0;
			term_dq <= 1'b0;
			term_tdqs <= 1'b0;
			tdqs_en <= `DPI_TDQS_EN_RST;
			odt_en <= `DPI_ODT_EN_RST;
			cmd_valid <= 1'b0;
			cmd_code <= `DPI_CMD_NOP;
			wr_data <= 8'h00;
			wr_valid <= 1'b0;
			wr_last <= 1'b0;
			rd_take <= 1'b0;
		end else if (reset) begin
			ck_prev_r <= 1'b0;
			dqs_prev_r <= 1'b0;
			wr_beats_r <= 4'h0;
			rd_beats_r <= 4'h0;
			dq_out <= 8'h00;
			dq_oe <= 1'b0;
			dqs_out <= 1'b0;
			dqs_n_out <= 1'b1;
			dqs_oe <= 1'b0;
			term_dq <= 1'b0;
			term_tdqs <= 1'b0;
			tdqs_en <= `DPI_TDQS_EN_RST;
			odt_en <= `DPI_ODT_EN_RST;
			cmd_valid <= 1'b0;
			cmd_code <= `DPI_CMD_NOP;
			wr_data <= 8'h00;
			wr_valid <= 1'b0;
			wr_last <= 1'b0;
			rd_take <= 1'b0;
		end else begin
			ck_prev_r <= ck_f;
			dqs_prev_r <= dqs_f;
			cmd_valid <= 1'b0;
			wr_valid <= 1'b0;
			wr_last <= 1'b0;
			rd_take <= 1'b0;

			if (ck_rise) begin
				// terminate only while not driving a read burst
				term_dq <= odt_f & odt_en_nxt & ~drive_nxt;
				term_tdqs <= odt_f & odt_en_nxt & tdqs_en_nxt & ~drive_nxt;
				if (cmd_now != `DPI_CMD_NOP) begin
					cmd_valid <= 1'b1;
					cmd_code <= cmd_now;
				end
				if (mr_load) begin
					odt_en <= odt_en_nxt;
					tdqs_en <= tdqs_en_nxt;
				end
				// a new burst only starts once the bus is idle
				if (cmd_now == `DPI_CMD_WR && wr_beats_r == 4'h0 && rd_beats_r == 4'h0) begin
					wr_beats_r <= `DPI_BURST_BEATS;
				end
				if (cmd_now == `DPI_CMD_RD && wr_beats_r == 4'h0 && rd_beats_r == 4'h0) begin
					rd_beats_r <= `DPI_BURST_BEATS;
					dq_oe <= 1'b1;
					dqs_oe <= 1'b1;
				end
			end

			// write beat on each strobe edge, both directions
			if (dqs_edge && wr_beats_r != 4'h0) begin
				wr_beats_r <= wr_beats_nxt;
				wr_data <= dq_f;
				wr_valid <= ~(dm_f & ~tdqs_en);
				wr_last <= (wr_beats_nxt == 4'h0);
			end

			// read beat on each ck edge; strobe flips with the data
			if (ck_edge && !ck_rise && rd_beats_r != 4'h0) begin
				rd_beats_r <= rd_beats_nxt;
				dq_out <= rd_data;
				dqs_out <= ~dqs_out;
				dqs_n_out <= dqs_out;
				rd_take <= 1'b1;
			end else if (ck_edge && ck_rise && rd_beats_r != 4'h0 && rd_beats_r != `DPI_BURST_BEATS) begin
				rd_beats_r <= rd_beats_nxt;
				dq_out <= rd_data;
				dqs_out <= ~dqs_out;
				dqs_n_out <= dqs_out;
				rd_take <= 1'b1;
			end else if (ck_edge && rd_beats_r == 4'h0 && dq_oe && !(ck_rise && cmd_now == `DPI_CMD_RD)) begin
				// release the shared bus one half clock after the last beat
				dq_oe <= 1'b0;
				dqs_oe <= 1'b0;
			end
		end
	end
endmodule

// ---- pkg/dpi_regs.vh ----
// Purpose: shared constants of the x8 data pin interface
// Assumes: plain Verilog-2005, included by bare name
// Notes: definitions only
`ifndef DPI_REGS_VH
`define DPI_REGS_VH

// ********************************
// burst and mode register fields
// ********************************
`define DPI_BURST_BEATS 4'h8
`define DPI_MR_ODT_TDQS 3'h1
`define DPI_RTT_BIT0 2
`define DPI_RTT_BIT1 6
`define DPI_RTT_BIT2 9
`define DPI_TDQS_BIT 11

// ********************************
// command codes {ras_n,cas_n,we_n}
// ********************************
`define DPI_CMD_MRS 3'h0
`define DPI_CMD_REF 3'h1
`define DPI_CMD_PRE 3'h2
`define DPI_CMD_ACT 3'h3
`define DPI_CMD_WR 3'h4
`define DPI_CMD_RD 3'h5
`define DPI_CMD_ZQ 3'h6
`define DPI_CMD_NOP 3'h7

// ********************************
// reset values
// ********************************
`define DPI_ODT_EN_RST 1'h1
`define DPI_TDQS_EN_RST 1'h0

`endif

// ---- rtl/dpi_sync3.v ----
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to clk_sys
// Notes: output moves only when stages two and three agree
module dpi_sync3 #(
	parameter W = 1
) (
	input wire clk_sys,
	input wire reset,
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
	reg [W-1:0] s1_r;
	reg [W-1:0] s2_r;
	reg [W-1:0] s3_r;

	// first stage feeds only the second, for metastability
	always @(posedge clk_sys) begin
		if (reset) begin
			s1_r <= {W{1'b0}};
			s2_r <= {W{1'b0}};
			s3_r <= {W{1'b0}};
			q <= {W{1'b0}};
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			// each bit moves on its own, so a busy data pin never stalls ck
			q <= (q & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
		end
	end
endmodule

// ---- dv/dpi_checker.sv ----
// Purpose: port assertions for dpi_pin_if
// Assumes: one clk_sys domain
// Notes: either reset disables checks
module dpi_checker (
	input wire clk_sys,
	input wire reset,
	input wire mem_reset_n,
	input wire [7:0] rd_data,
	input wire [7:0] dq_out,
	input wire dq_oe,
	input wire dqs_out,
	input wire dqs_n_out,
	input wire dqs_oe,
	input wire term_dq,
	input wire term_tdqs,
	input wire tdqs_en,
	input wire odt_en,
	input wire cmd_valid,
	input wire wr_valid,
	input wire rd_take
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset || !mem_reset_n);
	sequence s_rd_open;
		$rose(dq_oe);
	endsequence
	sequence s_rd_close;
		$fell(dq_oe);
	endsequence
	a_oe_pair: assert property (dq_oe == dqs_oe)
		else $error("oe pair split");
	a_strobe_diff: assert property (dqs_oe |-> dqs_n_out != dqs_out)
		else $error("strobe not differential");
	a_rd_beat: assert property (rd_take |-> dq_oe && dq_out == $past(rd_data) && dqs_out != $past(dqs_out))
		else $error("bad read beat");
	a_rd_first: assert property (s_rd_open |-> ##[1:20] rd_take)
		else $error("no first beat");
	a_rd_end: assert property (s_rd_close |-> !dqs_out && !rd_take)
		else $error("bad burst end");
	a_odt_gate: assert property (term_dq |-> odt_en && !dq_oe)
		else $error("termination while disabled");
	a_tdqs_term: assert property (term_tdqs |-> tdqs_en && term_dq)
		else $error("tdqs termination wrong");
	a_cmd_pulse: assert property (cmd_valid |=> !cmd_valid)
		else $error("command pulse too long");
	a_bus_turn: assert property (dq_oe |-> !wr_valid)
		else $error("write during read drive");
endmodule
bind dpi_pin_if dpi_checker u_chk (.clk_sys, .reset, .mem_reset_n, .rd_data, .dq_out, .dq_oe, .dqs_out,
	.dqs_n_out, .dqs_oe, .term_dq, .term_tdqs, .tdqs_en, .odt_en, .cmd_valid, .wr_valid, .rd_take);

// ---- dv/dpi_ctrl.sv ----
// Purpose: controller model on the x8 pins
// Assumes: ck runs free at 48 ns
// Notes: released bus shows inverted last byte
module dpi_ctrl (
	input wire clk_sys,
	output logic ck,
	output logic cs_n,
	output logic [2:0] rcw_n,
	output logic odt,
	output logic [2:0] ba,
	output logic [13:0] addr,
	output logic dm,
	output logic [7:0] dq,
	output logic dqs
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		{ck, cs_n, rcw_n} = 5'h0F;
		{odt, ba, addr, dm, dq, dqs} = 28'h0;
		#3;
		forever #24 ck = ~ck;
	end
	// pins move while ck is low, steady round its rise
	task cmd(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a, input logic o);
		@(negedge ck);
		@(posedge clk_sys);
		{cs_n, rcw_n} <= c;
		ba <= b;
		addr <= a;
		odt <= o;
		@(negedge ck);
		@(posedge clk_sys);
		{cs_n, rcw_n} <= 4'hF;
	endtask
	task wr(input logic [63:0] d, input logic [7:0] m);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_sys);
			dq <= d[8*i+:8];
			dm <= m[i];
			repeat (3) @(posedge clk_sys);
			dqs <= ~dqs;
			repeat (3) @(posedge clk_sys);
		end
		dq <= ~dq;
	endtask
endmodule

// ---- dv/dpi_tb.sv ----
// Purpose: self-checking bench for dpi_pin_if
// Assumes: checker bound, controller model on pins
// Notes: driver queues expected results
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys, reset, mem_reset_n;
	logic [7:0] rd_data, m;
	logic [63:0] d;
	wire ck, cs_n, odt, dm, dqs_m, dq_oe, dqs_out, dqs_n_out, dqs_oe, term_dq, term_tdqs, tdqs_en;
	wire odt_en, cmd_valid, wr_valid, wr_last, rd_take;
	wire [2:0] rcw_n, ba, cmd_code;
	wire [13:0] addr;
	wire [7:0] dq_m, dq_out, wr_data;
	logic [7:0] qw[$], qr[$];
	logic [2:0] qc[$];
	int err_count, checked, wl, i;
	int seed = 32'h033e;
	dpi_pin_if dut (.clk_sys, .reset, .mem_reset_n, .ck, .cs_n, .ras_n(rcw_n[2]), .cas_n(rcw_n[1]),
		.we_n(rcw_n[0]), .odt, .ba, .addr, .dm_in(dm), .dq_in(dq_oe ? dq_out : dq_m), .dq_out, .dq_oe,
		.dqs_in(dqs_oe ? dqs_out : dqs_m), .dqs_out, .dqs_n_out, .dqs_oe, .term_dq, .term_tdqs, .tdqs_en,
		.odt_en, .cmd_valid, .cmd_code, .wr_data, .wr_valid, .wr_last, .rd_data, .rd_take);
	dpi_ctrl ctrl (.clk_sys, .ck, .cs_n, .rcw_n, .odt, .ba, .addr, .dm, .dq(dq_m), .dqs(dqs_m));
	initial begin
		clk_sys = 0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task end_sim;
		if (err_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task check(input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task drain;
		for (int n = 0; qc.size() + qw.size() + qr.size() + dq_oe; n++)
			if (n > 400) begin
				err_count++;
				end_sim;
			end else
				@(posedge clk_sys);
		repeat (12) @(posedge clk_sys);
	endtask
	task wburst(input logic tq);
		d = {$random(seed), $random(seed)};
		m = 8'($random(seed));
		qc.push_back(3'h4);
		ctrl.cmd(4'h4, 3'h0, 14'h0, 1'b0);
		for (i = 0; i < 8; i++)
			if (!m[i] || tq) qw.push_back(d[8*i+:8]);
		ctrl.wr(d, m);
		drain;
	endtask
	always @(posedge clk_sys) begin
		if (cmd_valid === 1'b1) check(cmd_code, qc.pop_front());
		if (wr_valid === 1'b1) check(wr_data, qw.pop_front());
		if (rd_take === 1'b1) check(dq_out, qr.pop_front());
		if (wr_last === 1'b1) wl++;
	end
	initial begin
		reset = 1;
		mem_reset_n = 1;
		rd_data = 8'h00;
		repeat (6) @(posedge clk_sys);
		reset <= 0;
		repeat (5) @(posedge clk_sys);
		check({dqs_n_out, cmd_code, odt_en, tdqs_en}, 8'h3E);
		for (i = 0; i < 8; i++)
			if (i != 4 && i != 5) begin
				if (i < 7) qc.push_back(i[2:0]);
				ctrl.cmd({1'b0, i[2:0]}, 3'h2, 14'($random(seed)), 1'b1);
			end
		drain;
		check(term_dq, 1'b1);
		ctrl.cmd(4'h8, 3'h1, 14'h0, 1'b0);
		drain;
		check({odt_en, term_dq}, 8'h2);
		wburst(1'b0);
		m = 8'($random(seed));
		rd_data <= m;
		qc.push_back(3'h5);
		repeat (8) qr.push_back(m);
		ctrl.cmd(4'h5, 3'h0, 14'h0, 1'b1);
		drain;
		qc.push_back(3'h0);
		ctrl.cmd(4'h0, 3'h1, 14'h0, 1'b1);
		drain;
		check({odt_en, term_dq}, 8'h0);
		qc.push_back(3'h0);
		ctrl.cmd(4'h0, 3'h1, 14'h0804, 1'b1);
		ctrl.cmd(4'hF, 3'h0, 14'h0, 1'b1);
		drain;
		check({tdqs_en, term_tdqs}, 8'h3);
		wburst(1'b1);
		check(wl, 8'h2);
		@(posedge clk_sys);
		mem_reset_n <= 0;
		#1;
		check(tdqs_en, 1'b0);
		@(posedge clk_sys);
		mem_reset_n <= 1;
		repeat (12) @(posedge clk_sys);
		check({dqs_n_out, cmd_code, odt_en, tdqs_en}, 8'h3E);
		end_sim;
	end
endmodule
